/* hw/uhp_regs_defs.vh */
`ifndef UHP_REGS_DEFS_VH
`define UHP_REGS_DEFS_VH

// register addresses
`define UHP_A_TX_FIFO_DATA      5'h00
`define UHP_A_TX_COUNT_LOW      5'h01
`define UHP_A_TX_COUNT_HIGH     5'h02
`define UHP_A_TX_CONTROL        5'h03
`define UHP_A_TX_FLAGS          5'h04
`define UHP_A_RX_FIFO_DATA      5'h05
`define UHP_A_RX_COUNT_LOW      5'h06
`define UHP_A_RX_COUNT_HIGH     5'h07
`define UHP_A_RX_CONTROL        5'h08
`define UHP_A_RX_FLAGS          5'h09
`define UHP_A_EP_SELECTOR       5'h0A
`define UHP_A_EP_CONTROL        5'h0B
`define UHP_A_EP_TX_STATUS      5'h0C
`define UHP_A_EP_RX_STATUS      5'h0D
`define UHP_A_FRAME_LOW         5'h0E
`define UHP_A_FRAME_HIGH        5'h0F
`define UHP_A_FUNC_ADDR         5'h10
`define UHP_A_SYS_CONTROL       5'h11
`define UHP_A_SYS_STATUS        5'h12
`define UHP_A_HOLE_0            5'h13
`define UHP_A_EVENT_FLAGS_0     5'h14
`define UHP_A_EVENT_FLAGS_1     5'h15
`define UHP_A_EVENT_ENABLE_0    5'h16
`define UHP_A_EVENT_ENABLE_1    5'h17
`define UHP_A_HW_REVISION       5'h18
`define UHP_A_SUSPEND_LOCK      5'h19
`define UHP_A_UPDATE_HOLD       5'h1A
`define UHP_A_FW_SCRATCH        5'h1B
`define UHP_A_MISC_CTRL_STAT    5'h1C
`define UHP_A_DSET_READY_0      5'h1D
`define UHP_A_DSET_READY_1      5'h1E
`define UHP_A_HOLE_1            5'h1F

// per-endpoint storage slots
`define UHP_EP_SLOTS            9
`define UHP_SLOT_W              4
`define UHP_SLOT_NONE           4'hF
`define UHP_EP_COUNT            16
`define UHP_EP_W                4

// reset and default values
`define UHP_BYTE_ZERO           8'h00
`define UHP_ADDR_ZERO           5'h00
`define UHP_REG_COUNT           32
`define UHP_UNMAPPED_READ       8'h00
`define UHP_REVISION_DEFAULT    8'h5A
`define UHP_PIN_IDLE            1'b1

// host spacing figures (kept by the host, see note)
`define UHP_CLK_PERIOD_NS       50
`define UHP_WRITE_SPACING_NS    86
`define UHP_RX_READ_SPACING_NS  86
`define UHP_WRITE_SPACING_CYC   ((`UHP_WRITE_SPACING_NS + `UHP_CLK_PERIOD_NS - 1) / `UHP_CLK_PERIOD_NS)

`endif

/* hw/uhp_pin_sync.v */
`timescale 1ns/10ps
`default_nettype none

// three-stage pin synchroniser; output follows once stages two and three agree
module uhp_pin_sync #(
    parameter       WIDTH    = 1,
    parameter [0:0] IDLE_VAL = 1'b0
) (
    // clock and reset
    input  wire             mclk_i,
    input  wire             srst_i,
    // pins and filtered level
    input  wire [WIDTH-1:0] pin_i,
    output wire [WIDTH-1:0] level_o
);

    reg [WIDTH-1:0] s1_reg;
    reg [WIDTH-1:0] s2_reg;
    reg [WIDTH-1:0] s3_reg;
    reg [WIDTH-1:0] level_reg;

    always @(posedge mclk_i) begin
        if (srst_i) begin
            s1_reg    <= {WIDTH{IDLE_VAL}};
            s2_reg    <= {WIDTH{IDLE_VAL}};
            s3_reg    <= {WIDTH{IDLE_VAL}};
            level_reg <= {WIDTH{IDLE_VAL}};
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                level_reg <= s3_reg;
            end
        end
    end

    assign level_o = level_reg;

endmodule // uhp_pin_sync

`default_nettype wire

/* hw/uhp_host_port.v */
`timescale 1ns/10ps
`default_nettype none
`include "uhp_regs_defs.vh"

module uhp_host_port #(
    parameter [7:0] REVISION = `UHP_REVISION_DEFAULT // arbitrary value
) (
    // clock and reset
    input  wire        mclk_i,
    input  wire        srst_i,
    // host bus pins
    input  wire [4:0]  addr_i,
    input  wire [7:0]  data_i,
    output wire [7:0]  data_o,
    output wire        data_oe_o,
    input  wire        chip_select_n_i,
    input  wire        read_strobe_n_i,
    input  wire        write_strobe_n_i,
    // transmit fifo side
    output wire        tx_push_o,
    output wire [7:0]  tx_data_o,
    // receive fifo side
    output wire        rx_pop_o,
    input  wire [7:0]  rx_data_i,
    input  wire [15:0] rx_count_i,
    // core status
    input  wire [15:0] frame_number_i,
    input  wire [15:0] dset_ready_i,
    input  wire [15:0] event_set_i,
    // core control
    output wire [3:0]  endpoint_o,
    output wire [7:0]  ep_control_o,
    output wire [7:0]  function_address_o,
    output wire [7:0]  system_control_o,
    output wire [15:0] event_flags_o,
    output wire [15:0] event_enable_o
);

    // slot of a per-endpoint register with storage, none for others
    function [`UHP_SLOT_W-1:0] ep_slot;
        input [4:0] a;
        begin
            case (a)
                `UHP_A_TX_COUNT_LOW:  ep_slot = 4'h0;
                `UHP_A_TX_COUNT_HIGH: ep_slot = 4'h1;
                `UHP_A_TX_CONTROL:    ep_slot = 4'h2;
                `UHP_A_TX_FLAGS:      ep_slot = 4'h3;
                `UHP_A_RX_CONTROL:    ep_slot = 4'h4;
                `UHP_A_RX_FLAGS:      ep_slot = 4'h5;
                `UHP_A_EP_CONTROL:    ep_slot = 4'h6;
                `UHP_A_EP_TX_STATUS:  ep_slot = 4'h7;
                `UHP_A_EP_RX_STATUS:  ep_slot = 4'h8;
                default:              ep_slot = `UHP_SLOT_NONE;
            endcase
        end
    endfunction

    // global registers held in plain storage
    function is_global_rw;
        input [4:0] a;
        begin
            case (a)
                `UHP_A_EP_SELECTOR, `UHP_A_FUNC_ADDR, `UHP_A_SYS_CONTROL,
                `UHP_A_SYS_STATUS, `UHP_A_EVENT_ENABLE_0, `UHP_A_EVENT_ENABLE_1,
                `UHP_A_SUSPEND_LOCK, `UHP_A_UPDATE_HOLD, `UHP_A_FW_SCRATCH,
                `UHP_A_MISC_CTRL_STAT: is_global_rw = 1'b1;
                default:               is_global_rw = 1'b0;
            endcase
        end
    endfunction

    // flat storage index of one endpoint's slot, cut to the eight index bits
    function [7:0] ep_index;
        input [`UHP_EP_W-1:0]   sel;
        input [`UHP_SLOT_W-1:0] slot;
        reg   [31:0]            full;
        begin
            full     = sel * `UHP_EP_SLOTS + slot;
            ep_index = full[7:0];
        end
    endfunction

    // pin synchronisers; pins reach the logic four clocks late, so select and
    // strobe levels, active or idle, shorter than two clocks are not seen
    wire [4:0] addr_s;
    wire [7:0] data_s;
    wire [2:0] strobe_s;

    uhp_pin_sync #(
        .WIDTH    (5),
        .IDLE_VAL (1'b0)
    ) u_addr_sync (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .pin_i   (addr_i),
        .level_o (addr_s)
    );

    uhp_pin_sync #(
        .WIDTH    (8),
        .IDLE_VAL (1'b0)
    ) u_data_sync (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .pin_i   (data_i),
        .level_o (data_s)
    );

    uhp_pin_sync #(
        .WIDTH    (3),
        .IDLE_VAL (`UHP_PIN_IDLE)
    ) u_strobe_sync (
        .mclk_i  (mclk_i),
        .srst_i  (srst_i),
        .pin_i   ({chip_select_n_i, read_strobe_n_i, write_strobe_n_i}),
        .level_o (strobe_s)
    );

    wire cs_act = ~strobe_s[2];
    wire rd_act = cs_act & ~strobe_s[1];
    wire wr_act = cs_act & ~strobe_s[0];

    // access tracking
    reg        rd_act_reg;
    reg        wr_act_reg;
    reg [4:0]  rd_addr_reg;
    reg [4:0]  wr_addr_reg;
    reg [7:0]  wr_data_reg;
    reg [7:0]  rdata_reg;
    reg        tx_push_reg;
    reg [7:0]  tx_data_reg;
    reg        rx_pop_reg;

    // write commits when the strobe pair ends, using the last sampled address and data
    // the host must therefore hold address and data until its strobes rise
    wire       wr_commit = wr_act_reg & ~wr_act;
    wire       rd_done   = rd_act_reg & ~rd_act;

    // storage
    reg  [7:0] ep_mem [0:`UHP_EP_COUNT*`UHP_EP_SLOTS-1];
    reg  [7:0] glob_mem [0:`UHP_REG_COUNT-1];
    reg  [15:0] flags_reg;

    wire [3:0] ep_sel = glob_mem[`UHP_A_EP_SELECTOR][`UHP_EP_W-1:0];
    wire [`UHP_SLOT_W-1:0] wr_slot = ep_slot(wr_addr_reg);
    wire [`UHP_SLOT_W-1:0] rd_slot = ep_slot(addr_s);
    wire [7:0] wr_index = ep_index(ep_sel, wr_slot);
    wire [7:0] rd_index = ep_index(ep_sel, rd_slot);

    integer i;
    integer j;

    always @(posedge mclk_i) begin
        if (srst_i) begin
            rd_act_reg  <= 1'b0;
            wr_act_reg  <= 1'b0;
            rd_addr_reg <= `UHP_ADDR_ZERO;
            wr_addr_reg <= `UHP_ADDR_ZERO;
            wr_data_reg <= `UHP_BYTE_ZERO;
        end else begin
            rd_act_reg  <= rd_act;
            wr_act_reg  <= wr_act;
            if (rd_act) begin
                rd_addr_reg <= addr_s;
            end
            if (wr_act) begin
                wr_addr_reg <= addr_s;
                wr_data_reg <= data_s;
            end
        end
    end

    // fifo strobes last one cycle; the pushed byte stays until the next push
    // a read of the receive port pops only once that read has ended
    wire tx_hit = wr_commit && (wr_addr_reg == `UHP_A_TX_FIFO_DATA);
    wire rx_hit = rd_done && (rd_addr_reg == `UHP_A_RX_FIFO_DATA);

    always @(posedge mclk_i) begin
        if (srst_i) begin
            tx_push_reg <= 1'b0;
            tx_data_reg <= `UHP_BYTE_ZERO;
            rx_pop_reg  <= 1'b0;
        end else begin
            tx_push_reg <= tx_hit;
            rx_pop_reg  <= rx_hit;
            if (tx_hit) begin
                tx_data_reg <= wr_data_reg;
            end
        end
    end

    // per-endpoint register writes land in the selected endpoint's copy
    always @(posedge mclk_i) begin
        if (srst_i) begin
            for (i = 0; i < `UHP_EP_COUNT*`UHP_EP_SLOTS; i = i + 1) begin
                ep_mem[i] <= `UHP_BYTE_ZERO;
            end
        end else if (wr_commit && wr_slot != `UHP_SLOT_NONE) begin
            ep_mem[wr_index] <= wr_data_reg;
        end
    end

    // global register writes; unmapped and read-only addresses are dropped
    always @(posedge mclk_i) begin
        if (srst_i) begin
            for (j = 0; j < `UHP_REG_COUNT; j = j + 1) begin
                glob_mem[j] <= `UHP_BYTE_ZERO;
            end
        end else if (wr_commit && is_global_rw(wr_addr_reg)) begin
            glob_mem[wr_addr_reg] <= wr_data_reg;
        end
    end

    // event flags: a hardware set in the clearing cycle wins
    wire [15:0] flags_next;

    genvar k;
    generate
        for (k = 0; k < 16; k = k + 1) begin : g_flag
            wire hit = wr_commit && (wr_addr_reg ==
                       ((k < 8) ? `UHP_A_EVENT_FLAGS_0 : `UHP_A_EVENT_FLAGS_1));
            assign flags_next[k] = event_set_i[k] ? 1'b1 :
                                   (hit ? wr_data_reg[k % 8] : flags_reg[k]);
        end
    endgenerate

    always @(posedge mclk_i) begin
        if (srst_i) begin
            flags_reg <= {2{`UHP_BYTE_ZERO}};
        end else begin
            flags_reg <= flags_next;
        end
    end

    // read data mux; reserved bits return whatever is stored
    reg [7:0] rd_mux;

    always @* begin
        rd_mux = `UHP_UNMAPPED_READ;
        if (rd_slot != `UHP_SLOT_NONE) begin
            rd_mux = ep_mem[rd_index];
        end else if (is_global_rw(addr_s)) begin
            rd_mux = glob_mem[addr_s];
        end else begin
            case (addr_s)
                `UHP_A_RX_FIFO_DATA:   rd_mux = rx_data_i;
                `UHP_A_RX_COUNT_LOW:   rd_mux = rx_count_i[7:0];
                `UHP_A_RX_COUNT_HIGH:  rd_mux = rx_count_i[15:8];
                `UHP_A_FRAME_LOW:      rd_mux = frame_number_i[7:0];
                `UHP_A_FRAME_HIGH:     rd_mux = frame_number_i[15:8];
                `UHP_A_EVENT_FLAGS_0:  rd_mux = flags_reg[7:0];
                `UHP_A_EVENT_FLAGS_1:  rd_mux = flags_reg[15:8];
                `UHP_A_HW_REVISION:    rd_mux = REVISION;
                `UHP_A_DSET_READY_0:   rd_mux = dset_ready_i[7:0];
                `UHP_A_DSET_READY_1:   rd_mux = dset_ready_i[15:8];
                default:               rd_mux = `UHP_UNMAPPED_READ;
            endcase
        end
    end

    // read data register follows the addressed value while the read is open
    always @(posedge mclk_i) begin
        if (srst_i) begin
            rdata_reg <= `UHP_BYTE_ZERO;
        end else if (rd_act) begin
            rdata_reg <= rd_mux;
        end
    end

    // outputs
    assign data_o             = rdata_reg;
    assign data_oe_o          = rd_act_reg;
    assign tx_push_o          = tx_push_reg;
    assign tx_data_o          = tx_data_reg;
    assign rx_pop_o           = rx_pop_reg;
    assign endpoint_o         = ep_sel;
    assign ep_control_o       = ep_mem[ep_index(ep_sel, ep_slot(`UHP_A_EP_CONTROL))];
    assign function_address_o = glob_mem[`UHP_A_FUNC_ADDR];
    assign system_control_o   = glob_mem[`UHP_A_SYS_CONTROL];
    assign event_flags_o      = flags_reg;
    assign event_enable_o     = {glob_mem[`UHP_A_EVENT_ENABLE_1], glob_mem[`UHP_A_EVENT_ENABLE_0]};

endmodule // uhp_host_port

`default_nettype wire

/* tb/uhp_host_port_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module uhp_host_port_chk (
    // clock and reset
    input wire logic        mclk_i,
    input wire logic        srst_i,
    // host pins
    input wire logic [4:0]  addr_i,
    input wire logic [7:0]  data_o,
    input wire logic        data_oe_o,
    input wire logic        chip_select_n_i,
    input wire logic        read_strobe_n_i,
    input wire logic        write_strobe_n_i,
    // core side
    input wire logic        tx_push_o,
    input wire logic [7:0]  tx_data_o,
    input wire logic        rx_pop_o,
    input wire logic [7:0]  rx_data_i,
    input wire logic [15:0] event_set_i,
    input wire logic [15:0] event_flags_o,
    input wire logic [3:0]  endpoint_o
);
    // cycles since the write strobe was last seen low
    logic [3:0] wr_age_reg;
    always @(posedge mclk_i) begin
        if (srst_i || !write_strobe_n_i) wr_age_reg <= 4'h0;
        else if (wr_age_reg != 4'hF) wr_age_reg <= wr_age_reg + 4'h1;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (srst_i);
    sequence s_rd_idle; read_strobe_n_i [*8]; endsequence
    sequence s_pulse_end; !tx_push_o; endsequence
    AST_RST:
    assert property (disable iff (1'b0) srst_i |=> !data_oe_o && !tx_push_o && !rx_pop_o
        && endpoint_o == 4'h0 && event_flags_o == 16'h0000) else $error("reset state wrong");
    AST_OE_CAUSE:
    assert property ($rose(data_oe_o) |-> $past(!chip_select_n_i && !read_strobe_n_i, 3))
        else $error("data bus driven without a read");
    AST_OE_END:
    assert property (s_rd_idle |-> !data_oe_o) else $error("data bus still driven");
    AST_RX_DATA:
    assert property (data_oe_o && addr_i == 5'h05 && $stable(rx_data_i) |-> data_o == rx_data_i)
        else $error("receive port read wrong");
    AST_HOLE:
    assert property (data_oe_o && (addr_i == 5'h13 || addr_i == 5'h1F) |-> data_o == 8'h00)
        else $error("unmapped read not zero");
    AST_PUSH:
    assert property (tx_push_o |-> addr_i == 5'h00 && write_strobe_n_i ##1 s_pulse_end)
        else $error("transmit push misplaced");
    AST_POP:
    assert property (rx_pop_o |-> addr_i == 5'h05 && read_strobe_n_i)
        else $error("receive pop misplaced");
    AST_TX_DATA:
    assert property ($changed(tx_data_o) |-> tx_push_o) else $error("tx data moved alone");
    AST_EP:
    assert property ($changed(endpoint_o) |-> wr_age_reg < 4'hA)
        else $error("endpoint moved without write");
    AST_EVENT:
    assert property (|event_set_i |=> (event_flags_o & $past(event_set_i)) == $past(event_set_i))
        else $error("event flag not set");
endmodule // uhp_host_port_chk
bind uhp_host_port uhp_host_port_chk uhp_host_port_chk_i (.mclk_i, .srst_i, .addr_i, .data_o,
    .data_oe_o, .chip_select_n_i, .read_strobe_n_i, .write_strobe_n_i, .tx_push_o, .tx_data_o,
    .rx_pop_o, .rx_data_i, .event_set_i, .event_flags_o, .endpoint_o);
`default_nettype wire

/* tb/uhp_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module uhp_host_model (
    // clock
    input  wire logic       mclk_i,
    // command side
    input  wire logic       go_i,
    input  wire logic       wr_i,
    input  wire logic [4:0] cmd_addr_i,
    input  wire logic [7:0] cmd_data_i,
    output var  logic       done_o,
    output var  logic [7:0] rdata_o,
    // bus pins
    input  wire logic [7:0] bus_i,
    output var  logic [4:0] addr_o,
    output var  logic [7:0] data_o,
    output var  logic       cs_n_o,
    output var  logic       rd_n_o,
    output var  logic       wr_n_o
);
    initial begin
        done_o = 1'b0;
        rdata_o = 8'h00;
        addr_o = 5'h00;
        data_o = 8'h00;
        cs_n_o = 1'b1;
        rd_n_o = 1'b1;
        wr_n_o = 1'b1;
        forever begin
            @(posedge mclk_i);
            if (go_i === 1'b1) begin
                addr_o <= cmd_addr_i;
                data_o <= cmd_data_i;
                @(posedge mclk_i);
                cs_n_o <= 1'b0;
                rd_n_o <= wr_i;
                wr_n_o <= !wr_i;
                repeat (8) @(posedge mclk_i);
                rdata_o <= bus_i;
                cs_n_o <= 1'b1;
                rd_n_o <= 1'b1;
                wr_n_o <= 1'b1;
                // address held past the device's latency, then an idle gap
                repeat (10) @(posedge mclk_i);
                data_o <= ~data_o;
                done_o <= 1'b1;
                @(posedge mclk_i);
                done_o <= 1'b0;
            end
        end
    end
endmodule // uhp_host_model
`default_nettype wire

/* tb/uhp_host_port_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module uhp_host_port_bench;
    localparam logic [7:0] HARDWARE_REVISION = 8'hA7; // arbitrary revision value
    logic mclk_i = 1'b0, srst_i = 1'b1, go = 1'b0, wr = 1'b0, done, cs_n, rd_n, wr_n;
    logic [4:0] caddr = 5'h00, addr;
    logic [7:0] cdata = 8'h00, rdata, hdata, dout, last = 8'h00, rx_data = 8'h00, tx_data;
    logic [7:0] epctl, function_address, sctl;
    logic [15:0] evset = 16'h0000, eflags, eenable;
    logic oe, tx_push, rx_pop;
    logic [3:0] endpoint;
    wire [7:0] bus = oe ? dout : (!wr_n ? hdata : ~last);
    int fails = 0, checks = 0, pushes = 0, pops = 0;
    always #25 mclk_i = ~mclk_i;
    always @(posedge mclk_i) begin
        if (oe) last <= dout;
        if (tx_push === 1'b1) pushes++;
        if (rx_pop === 1'b1) pops++;
    end
    uhp_host_port #(.REVISION(HARDWARE_REVISION)) uhp_host_port_i (.mclk_i(mclk_i), .srst_i(srst_i),
        .addr_i(addr), .data_i(bus), .data_o(dout), .data_oe_o(oe), .chip_select_n_i(cs_n),
        .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .tx_push_o(tx_push),
        .tx_data_o(tx_data), .rx_pop_o(rx_pop), .rx_data_i(rx_data), .rx_count_i(16'h0123),
        .frame_number_i(16'h0E4D), .dset_ready_i(16'h1D2E), .event_set_i(evset),
        .endpoint_o(endpoint), .ep_control_o(epctl), .function_address_o(function_address),
        .system_control_o(sctl), .event_flags_o(eflags), .event_enable_o(eenable));
    uhp_host_model uhp_host_model_i (.mclk_i(mclk_i), .go_i(go), .wr_i(wr), .cmd_addr_i(caddr),
        .cmd_data_i(cdata), .done_o(done), .rdata_o(rdata), .bus_i(bus), .addr_o(addr),
        .data_o(hdata), .cs_n_o(cs_n), .rd_n_o(rd_n), .wr_n_o(wr_n));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic op(input logic w, input logic [4:0] a, input logic [7:0] d);
        int n;
        @(posedge mclk_i);
        go <= 1'b1;
        wr <= w;
        caddr <= a;
        cdata <= d;
        @(posedge mclk_i);
        go <= 1'b0;
        for (n = 0; n < 60 && done !== 1'b1; n++) @(posedge mclk_i);
        if (done !== 1'b1) chk("bus cycle end", 16'h0001, 16'h0000);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] e, input string what);
        op(1'b0, a, 8'h00);
        chk(what, 16'(e), 16'(rdata));
    endtask
    task automatic do_reset;
        srst_i <= 1'b1;
        repeat (10) @(posedge mclk_i);
        srst_i <= 1'b0;
    endtask
    task automatic t_reset;
        rd(5'h18, HARDWARE_REVISION, "revision");
        rd(5'h0A, 8'h00, "selector");
        op(1'b1, 5'h1B, 8'h3C);
        rd(5'h1B, 8'h3C, "scratch");
        do_reset;
        rd(5'h1B, 8'h00, "scratch after reset");
    endtask
    task automatic t_rw;
        logic [4:0] a[7] = '{5'h01, 5'h02, 5'h10, 5'h11, 5'h16, 5'h17, 5'h1B};
        for (int i = 0; i < 7; i++) op(1'b1, a[i], 8'hA0 + 8'(i));
        for (int i = 0; i < 7; i++) rd(a[i], 8'hA0 + 8'(i), "register readback");
        chk("function_address_o", 16'h00A2, 16'(function_address));
        chk("system_control_o", 16'h00A3, 16'(sctl));
        chk("event_enable_o", eenable, 16'hA5A4);
    endtask
    task automatic t_bank;
        op(1'b1, 5'h0A, 8'h03);
        op(1'b1, 5'h01, 8'h33);
        op(1'b1, 5'h0B, 8'hC3);
        op(1'b1, 5'h0A, 8'h07);
        op(1'b1, 5'h01, 8'h77);
        chk("endpoint_o", 16'h0007, 16'(endpoint));
        chk("ep_control_o", 16'h0000, 16'(epctl));
        op(1'b1, 5'h0A, 8'h03);
        rd(5'h01, 8'h33, "banked count");
        chk("ep_control_o", 16'h00C3, 16'(epctl));
    endtask
    task automatic t_fifo;
        op(1'b1, 5'h00, 8'hC3);
        op(1'b1, 5'h00, 8'h5A);
        chk("push count", 16'(pushes), 16'h0002);
        chk("tx_data_o", 16'(tx_data), 16'h005A);
        rx_data <= 8'h96;
        rd(5'h05, 8'h96, "rx port");
        rx_data <= 8'h69;
        rd(5'h05, 8'h69, "rx port again");
        chk("pop count", 16'(pops), 16'h0002);
        rd(5'h00, 8'h00, "tx port read");
    endtask
    task automatic t_refuse;
        logic [4:0] a[5] = '{5'h06, 5'h07, 5'h0E, 5'h1D, 5'h1E};
        logic [7:0] e[5] = '{8'h23, 8'h01, 8'h4D, 8'h2E, 8'h1D};
        for (int i = 0; i < 5; i++) op(1'b1, a[i], 8'hFF);
        for (int i = 0; i < 5; i++) rd(a[i], e[i], "read-only");
        op(1'b1, 5'h13, 8'hFF);
        op(1'b1, 5'h1F, 8'hFF);
        rd(5'h13, 8'h00, "hole 13");
        rd(5'h1F, 8'h00, "hole 1F");
        chk("function_address_o", 16'h00A2, 16'(function_address));
    endtask
    task automatic t_event;
        @(posedge mclk_i);
        evset <= 16'h0281;
        @(posedge mclk_i);
        evset <= 16'h0000;
        rd(5'h14, 8'h81, "flags 0");
        rd(5'h15, 8'h02, "flags 1");
        op(1'b1, 5'h14, 8'h00);
        chk("event_flags_o", eflags, 16'h0200);
        evset <= 16'h0001;
        op(1'b1, 5'h14, 8'h00);
        evset <= 16'h0000;
        chk("event_flags_o set wins", 16'h0201, eflags);
    endtask
    task automatic report_and_stop;
        if (fails == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk_i);
        fails++;
        report_and_stop;
    end
    initial begin
        do_reset;
        t_reset;
        t_rw;
        t_bank;
        t_fifo;
        t_refuse;
        t_event;
        report_and_stop;
    end
endmodule // uhp_host_port_bench
`default_nettype wire
